/* flash_ctl_regs.vh */
// Purpose: constants for the flash erase host controller
// Assumes: pclk at 10 MHz, APB with 32-bit data, word-mode flash bus
// Notes:   offsets are byte addresses, one aligned word each
`ifndef FLASH_CTL_REGS_VH
`define FLASH_CTL_REGS_VH

// ==========================================================
// register offsets
`define OFS_CMD      8'h00
`define OFS_ADDR     8'h04
`define OFS_WDATA    8'h08
`define OFS_STATUS   8'h0c

// ==========================================================
// operation codes written to the command register
`define OP_CHIP_ERASE  4'h1
`define OP_SECT_ERASE  4'h2
`define OP_ADD_SECTOR  4'h3
`define OP_SUSPEND     4'h4
`define OP_RESUME      4'h5
`define OP_RESET_CMD   4'h6
`define OP_READ        4'h7
`define OP_RAW_WRITE   4'h8
`define OP_HW_RESET    4'h9

// ==========================================================
// flash command words (word mode)
`define FA_UNLOCK1   19'h00555
`define FA_UNLOCK2   19'h002aa
`define FD_UNLOCK1   16'h00aa
`define FD_UNLOCK2   16'h0055
`define FD_SETUP     16'h0080
`define FD_CHIP      16'h0010
`define FD_SECTOR    16'h0030
`define FD_SUSPEND   16'h00b0
`define FD_RESUME    16'h0030
`define FD_RESET     16'h00f0

// ==========================================================
// status register fields
`define ST_BUSY      0
`define ST_MODE_LO   1
`define ST_RDY       4
`define ST_REFUSED   5
`define ST_WINDOW    6
`define ST_RDATA_LO  8

// ==========================================================
// timing
`define CLK_PERIOD_NS  100
`define WIN_US         50
`define SUSP_US        20
`define RST_PULSE_NS   500
`define SETTLE_NS      500
`define WIN_CYC        ((`WIN_US * 1000) / `CLK_PERIOD_NS)
`define SUSP_CYC       ((`SUSP_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RST_CYC        ((`RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETTLE_CYC     ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* flash_erase_host.v */
// Purpose: APB-controlled host that drives erase, suspend and resume on a parallel flash
// Assumes: flash pins are synchronous to pclk; word mode; one bus phase is 100 ns
// Notes:   software issues one operation at a time and polls the status register
`include "flash_ctl_regs.vh"

module flash_erase_host #(
    parameter [9:0] WIN_CYC    = `WIN_CYC,
    parameter [9:0] SUSP_CYC   = `SUSP_CYC,
    parameter [9:0] RST_CYC    = `RST_CYC,
    parameter [9:0] SETTLE_CYC = `SETTLE_CYC
) (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // flash pins
    output reg  [18:0] flash_addr,
    output reg  [15:0] dq_o,
    input  wire [15:0] dq_i,
    output reg         dq_oe,
    output reg         ce_n,
    output reg         we_n,
    output reg         oe_n,
    output reg         flash_reset_n,
    input  wire        ready_busy_n
);

    // ==========================================================
    // host view of the flash mode
    localparam [2:0] M_IDLE = 3'd0, M_CHIP = 3'd1, M_WIN = 3'd2, M_ERAS = 3'd3;
    localparam [2:0] M_SUSPING = 3'd4, M_SUSP = 3'd5, M_HWRST = 3'd6;
    // bus engine states
    localparam [2:0] E_IDLE = 3'd0, E_SET = 3'd1, E_WE = 3'd2, E_REC = 3'd3, E_RD = 3'd4;

    reg [2:0]  mode_r;
    reg [2:0]  eng_r;
    reg [3:0]  op_r;
    reg [2:0]  step_r;
    reg [9:0]  tmr_r;
    reg [18:0] addr_r;
    reg [15:0] wdata_r;
    reg [15:0] rdata_r;
    reg        refused_r;

    wire        apb_acc = psel & penable & ~pready;
    wire        wr_cmd  = apb_acc & pwrite & (paddr == `OFS_CMD);
    wire [3:0]  new_op  = pwdata[3:0];
    wire [18:0] sect_a  = {addr_r[18:12], 12'h000};
    wire        win_open = (mode_r == M_WIN) && (tmr_r < WIN_CYC);

    // ==========================================================
    // which operations each mode lets through
    reg ok;
    always @* begin
        ok = 1'b0;
        case (mode_r)
            M_IDLE:    ok = (new_op == `OP_CHIP_ERASE) | (new_op == `OP_SECT_ERASE) |
                            (new_op == `OP_RESET_CMD) | (new_op == `OP_READ) |
                            (new_op == `OP_RAW_WRITE) | (new_op == `OP_HW_RESET);
            M_CHIP:    ok = (new_op == `OP_READ) | (new_op == `OP_HW_RESET);
            // other commands but resume are let out in the window: all except a read or an added sector end it in the flash too
            M_WIN:     ok = (new_op != `OP_RESUME) && (new_op != 4'h0) && (new_op <= `OP_HW_RESET) &&
                            ((new_op != `OP_ADD_SECTOR) | win_open);
            M_ERAS:    ok = (new_op == `OP_SUSPEND) | (new_op == `OP_READ) |
                            (new_op == `OP_HW_RESET);
            M_SUSPING: ok = (new_op == `OP_READ) | (new_op == `OP_HW_RESET);
            M_SUSP:    ok = (new_op == `OP_RESUME) | (new_op == `OP_READ) | (new_op == `OP_RAW_WRITE) |
                            (new_op == `OP_RESET_CMD) | (new_op == `OP_HW_RESET);
            default:   ok = 1'b0;
        endcase
    end
    wire take = wr_cmd && ok && (eng_r == E_IDLE); // a running sequence cannot be broken into

    // ==========================================================
    // address and data of each bus write cycle
    reg [18:0] cyc_a;
    reg [15:0] cyc_d;
    always @* begin
        cyc_a = `FA_UNLOCK1;
        cyc_d = `FD_UNLOCK1;
        case (step_r)
            3'd0, 3'd3: begin
                cyc_a = `FA_UNLOCK1;
                cyc_d = `FD_UNLOCK1;
            end
            3'd1, 3'd4: begin
                cyc_a = `FA_UNLOCK2;
                cyc_d = `FD_UNLOCK2;
            end
            3'd2: begin
                cyc_a = `FA_UNLOCK1;
                cyc_d = `FD_SETUP;
            end
            default: begin
                case (op_r)
                    `OP_CHIP_ERASE: begin
                        cyc_a = `FA_UNLOCK1;
                        cyc_d = `FD_CHIP;
                    end
                    `OP_SECT_ERASE, `OP_ADD_SECTOR: begin
                        cyc_a = sect_a;
                        cyc_d = `FD_SECTOR;
                    end
                    `OP_SUSPEND: begin
                        cyc_a = 19'h00000;
                        cyc_d = `FD_SUSPEND;
                    end
                    `OP_RESUME: begin
                        cyc_a = 19'h00000;
                        cyc_d = `FD_RESUME;
                    end
                    `OP_RESET_CMD: begin
                        cyc_a = 19'h00000;
                        cyc_d = `FD_RESET;
                    end
                    default: begin
                        cyc_a = addr_r;
                        cyc_d = wdata_r;
                    end
                endcase
            end
        endcase
    end

    // ==========================================================
    // apb registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= 32'h00000000;
            addr_r    <= 19'h00000;
            wdata_r   <= 16'h0000;
            refused_r <= 1'b0;
        end else begin
            pready  <= apb_acc;
            pslverr <= apb_acc & (paddr[7:4] != 4'h0 || paddr[1:0] != 2'b00);
            if (apb_acc & pwrite & (paddr == `OFS_ADDR))
                addr_r <= pwdata[18:0];
            if (apb_acc & pwrite & (paddr == `OFS_WDATA))
                wdata_r <= pwdata[15:0];
            // a new refusal wins over a clear in the same cycle
            if (wr_cmd & ~take)
                refused_r <= 1'b1;
            else if (apb_acc & pwrite & (paddr == `OFS_STATUS) & pwdata[`ST_REFUSED])
                refused_r <= 1'b0;
            prdata <= 32'h00000000;
            if (apb_acc & ~pwrite) begin
                case (paddr)
                    `OFS_ADDR:   prdata <= {13'h0, addr_r};
                    `OFS_WDATA:  prdata <= {16'h0000, wdata_r};
                    `OFS_STATUS: prdata <= {8'h00, rdata_r, 1'b0, win_open, refused_r,
                                            ready_busy_n, mode_r, (eng_r != E_IDLE)};
                    default:     prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ==========================================================
    // bus engine and mode tracker
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            eng_r         <= E_IDLE;
            mode_r        <= M_IDLE;
            op_r          <= 4'h0;
            step_r        <= 3'd0;
            tmr_r         <= 10'd0;
            rdata_r       <= 16'h0000;
            flash_addr    <= 19'h00000;
            dq_o          <= 16'h0000;
            dq_oe         <= 1'b0;
            ce_n          <= 1'b1;
            we_n          <= 1'b1;
            oe_n          <= 1'b1;
            flash_reset_n <= 1'b1;
        end else begin
            if (tmr_r != 10'h3ff)
                tmr_r <= tmr_r + 10'd1;
            // autonomous mode changes
            case (mode_r)
                M_WIN: if (tmr_r >= WIN_CYC) begin
                    mode_r <= M_ERAS;
                    tmr_r  <= 10'd0;
                end
                // the pin is ignored for a while: it may not have fallen yet
                M_CHIP, M_ERAS: if (tmr_r >= SETTLE_CYC && ready_busy_n)
                    mode_r <= M_IDLE;
                M_SUSPING: if (tmr_r >= SUSP_CYC)
                    mode_r <= M_SUSP;
                M_HWRST: if (tmr_r >= RST_CYC) begin
                    flash_reset_n <= 1'b1;
                    mode_r        <= M_IDLE;
                end
                default: ;
            endcase
            case (eng_r)
                E_IDLE: if (take) begin
                    op_r <= new_op;
                    if (new_op == `OP_HW_RESET) begin
                        flash_reset_n <= 1'b0;
                        mode_r        <= M_HWRST;
                        tmr_r         <= 10'd0;
                    end else begin
                        step_r <= (new_op == `OP_CHIP_ERASE || new_op == `OP_SECT_ERASE) ? 3'd0 : 3'd5;
                        eng_r  <= E_SET;
                    end
                end
                E_SET: begin
                    ce_n       <= 1'b0;
                    flash_addr <= (op_r == `OP_READ) ? addr_r : cyc_a;
                    dq_o       <= cyc_d;
                    dq_oe      <= (op_r != `OP_READ);
                    oe_n       <= (op_r != `OP_READ);
                    eng_r      <= (op_r == `OP_READ) ? E_RD : E_WE;
                end
                E_WE: begin
                    we_n  <= 1'b0;
                    eng_r <= E_REC;
                end
                E_REC: begin
                    // data latches here; the window is timed from this rising edge
                    we_n  <= 1'b1;
                    ce_n  <= 1'b1;
                    dq_oe <= 1'b0;
                    if (step_r != 3'd5) begin
                        step_r <= step_r + 3'd1;
                        eng_r  <= E_SET;
                    end else begin
                        eng_r <= E_IDLE;
                        case (op_r)
                            `OP_CHIP_ERASE: begin
                                mode_r <= M_CHIP;
                                tmr_r  <= 10'd0;
                            end
                            `OP_SECT_ERASE: begin
                                mode_r <= M_WIN;
                                tmr_r  <= 10'd0;
                            end
                            // too late: the window closed while this cycle was on the bus
                            `OP_ADD_SECTOR: if (mode_r == M_WIN)
                                tmr_r <= 10'd0;
                            `OP_SUSPEND: begin
                                mode_r <= (mode_r == M_WIN) ? M_SUSP : M_SUSPING;
                                tmr_r  <= 10'd0;
                            end
                            `OP_RESUME: begin
                                mode_r <= M_ERAS;
                                tmr_r  <= 10'd0;
                            end
                            `OP_RESET_CMD, `OP_RAW_WRITE: if (mode_r == M_WIN)
                                mode_r <= M_IDLE;
                            default: ;
                        endcase
                    end
                end
                E_RD: begin
                    rdata_r <= dq_i;
                    ce_n    <= 1'b1;
                    oe_n    <= 1'b1;
                    eng_r   <= E_IDLE;
                end
                default: eng_r <= E_IDLE;
            endcase
        end
    end

endmodule // flash_erase_host

/* flash_host_sva.sv */
// Purpose: port checks for the flash erase host
// Assumes: one pclk domain, presetn async active low
// Notes:   bound to every flash_erase_host
module flash_host_sva #(parameter [9:0] RST_CYC = 10'd5) (
    // apb side
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // flash side
    input wire logic [18:0] flash_addr,
    input wire logic [15:0] dq_o,
    input wire logic        dq_oe,
    input wire logic        ce_n,
    input wire logic        we_n,
    input wire logic        oe_n,
    input wire logic        flash_reset_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [9:0] lo_r;
    // counts how long the hardware reset pin has been low
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            lo_r <= 10'd0;
        else
            lo_r <= flash_reset_n ? 10'd0 : lo_r + 10'd1;
    end
    // ==========================================
    // apb
    a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("apb wait not one cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_slverr_map: assert property (pready |-> pslverr == (paddr[7:4] != 4'h0 || paddr[1:0] != 2'h0))
        else $error("pslverr wrong");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero");
    // ==========================================
    // flash bus
    a_write_pulse: assert property ($fell(we_n) |-> !ce_n && oe_n && dq_oe ##1 we_n && ce_n && !dq_oe)
        else $error("bad write cycle");
    a_addr_hold: assert property (!ce_n && !$past(ce_n) |-> $stable(flash_addr) && $stable(dq_o))
        else $error("flash address moved");
    a_unlock_one: assert property (!we_n && dq_o[7:0] == 8'haa |-> flash_addr == 19'h00555)
        else $error("first unlock address");
    a_unlock_two: assert property (!we_n && dq_o[7:0] == 8'h55 |-> flash_addr == 19'h002aa)
        else $error("second unlock address");
    a_sector_addr: assert property (!we_n && dq_o[7:0] == 8'h30 |-> flash_addr[11:0] == 12'h000)
        else $error("sector address low bits");
    a_read_strobe: assert property (!oe_n |-> !ce_n && we_n && !dq_oe ##1 oe_n)
        else $error("bad read cycle");
    // the pin is low from the take edge and for RST_CYC further cycles
    a_reset_len: assert property ($rose(flash_reset_n) |-> lo_r == RST_CYC + 10'd1)
        else $error("reset pulse length");
endmodule // flash_host_sva

bind flash_erase_host flash_host_sva #(.RST_CYC(RST_CYC)) u_sva (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(flash_addr), .dq_o(dq_o), .dq_oe(dq_oe), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .flash_reset_n(flash_reset_n)
);

/* flash_model.sv */
// Purpose: behavioural parallel flash, erase command set only
// Assumes: pins sampled on pclk, word mode
// Notes:   queued sectors not tracked, so reads while busy give status
module flash_model #(
    parameter int WIN   = 40,
    parameter int ERASE = 300,
    parameter int SLOW  = 8
) (
    // clock and strobes
    input  wire logic        pclk,
    input  wire logic        ce_n,
    input  wire logic        we_n,
    input  wire logic        oe_n,
    input  wire logic        flash_reset_n,
    // address and data
    input  wire logic [18:0] flash_addr,
    input  wire logic [15:0] dq_o,
    output logic      [15:0] dq_i,
    output logic             ready_busy_n
);
    // st_r: 0 read, 1 chip erase, 2 window, 3 erasing, 4 suspended, 5 suspending
    // powers up in array read: the host never pulses the reset pin at start
    logic [2:0]  st_r = 3'd0;
    logic [2:0]  seq_r = 3'd0;
    logic [9:0]  tm_r = 10'd0;
    logic        tgl_r = 1'b0;
    logic [15:0] idle_r = 16'ha5a5;
    wire         wr = !ce_n && !we_n;
    wire  [7:0]  d = dq_o[7:0];
    wire  [7:0]  xd = (seq_r == 3'd1 || seq_r == 3'd4) ? 8'h55 : (seq_r == 3'd2) ? 8'h80 : 8'haa;
    wire  [10:0] xa = (xd == 8'h55) ? 11'h2aa : 11'h555;
    wire  [15:0] stat = {8'h00, st_r == 3'd4, tgl_r, 2'b00, st_r != 3'd2, tgl_r, 2'b00};
    assign dq_i = !oe_n ? (st_r == 3'd0 ? flash_addr[15:0] : stat) : idle_r;
    assign ready_busy_n = (st_r == 3'd0 || st_r == 3'd4);
    // released bus shows the inverse of the last value, never a held copy
    always @(posedge pclk) begin
        if (!oe_n) begin
            idle_r <= ~dq_i;
            tgl_r <= tgl_r ^ !ready_busy_n;
        end
    end
    // ==========================================
    // command decode
    always @(posedge pclk or negedge flash_reset_n) begin
        if (!flash_reset_n) begin
            st_r <= 3'd0;
            seq_r <= 3'd0;
            tm_r <= 10'd0;
        end else if (wr) begin
            tm_r <= 10'd0;
            case (st_r)
                3'd0: begin
                    if (seq_r == 3'd5) begin
                        seq_r <= 3'd0;
                        st_r <= (d == 8'h10) ? 3'd1 : (d == 8'h30) ? 3'd2 : 3'd0;
                    end else
                        seq_r <= (d == xd && flash_addr[10:0] == xa) ? seq_r + 3'd1 : 3'd0;
                end
                3'd2: st_r <= (d == 8'h30) ? 3'd2 : (d == 8'hb0) ? 3'd4 : 3'd0;
                3'd3: st_r <= (d == 8'hb0) ? 3'd5 : 3'd3;
                3'd4: st_r <= (d == 8'h30) ? 3'd3 : 3'd4;
                default: st_r <= st_r;
            endcase
        end else begin
            tm_r <= tm_r + 10'd1;
            if ((st_r == 3'd1 || st_r == 3'd3) && tm_r == ERASE)
                st_r <= 3'd0;
            else if (st_r == 3'd2 && tm_r == WIN) begin
                st_r <= 3'd3;
                tm_r <= 10'd0;
            end else if (st_r == 3'd5 && tm_r == SLOW)
                st_r <= 3'd4;
        end
    end
endmodule // flash_model

/* tb_top.sv */
// Purpose: self-checking bench for the flash erase host
// Assumes: shortened window and suspend counts
// Notes:   status polled over apb, flash side is flash_model
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sl;
    logic        dq_oe, ce_n, we_n, oe_n, flash_reset_n, ready_busy_n;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [18:0] flash_addr;
    logic [15:0] dq_o, dq_i;
    int          err_total, checks, cyc, i, k;

    flash_erase_host #(.WIN_CYC(10'd40), .SUSP_CYC(10'd10)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_addr(flash_addr), .dq_o(dq_o), .dq_i(dq_i), .dq_oe(dq_oe), .ce_n(ce_n),
        .we_n(we_n), .oe_n(oe_n), .flash_reset_n(flash_reset_n), .ready_busy_n(ready_busy_n));
    flash_model #(.WIN(40), .ERASE(300), .SLOW(8)) fm (
        .pclk(pclk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .flash_reset_n(flash_reset_n),
        .flash_addr(flash_addr), .dq_o(dq_o), .dq_i(dq_i), .ready_busy_n(ready_busy_n));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            test_done();
        end
    end
    // ==========================================
    // tasks
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        sl = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // leaves the status word in rd once the engine is idle
    task op(input logic [3:0] c);
        apb(1'b1, 8'h00, {28'h0, c});
        apb(1'b0, 8'h0c, 32'h0);
        for (i = 0; i < 20 && rd[0] !== 1'b0; i++) apb(1'b0, 8'h0c, 32'h0);
    endtask
    task st_mode(input logic [2:0] m);
        for (i = 0; i < 400; i++) begin
            apb(1'b0, 8'h0c, 32'h0);
            if (rd[3:1] === m) break;
        end
        chk({29'h0, rd[3:1]}, {29'h0, m});
    endtask
    task test_done;
        $display("comparisons %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ==========================================
    // tests
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h10);
        apb(1'b0, 8'h10, 32'h0);
        chk({rd[30:0], sl}, 32'h1);
        op(4'hf);
        chk({31'h0, rd[5]}, 32'h1);
        apb(1'b1, 8'h0c, 32'h20);
        apb(1'b1, 8'h04, 32'h01234);
        op(4'h7);
        chk({15'h0, rd[23:8], rd[5]}, 32'h2468);
        $display("test basic done");
        op(4'h1);
        st_mode(3'd1);
        chk({31'h0, rd[4]}, 32'h0);
        op(4'h4);
        chk({31'h0, rd[5]}, 32'h1);
        st_mode(3'd0);
        $display("test chip erase done");
        apb(1'b1, 8'h04, 32'h7f000);
        op(4'h2);
        chk({28'h0, rd[6], rd[3:1]}, 32'ha);
        apb(1'b1, 8'h04, 32'h03000);
        op(4'h3);
        st_mode(3'd3);
        chk({31'h0, rd[6]}, 32'h0);
        op(4'h4);
        st_mode(3'd5);
        op(4'h5);
        st_mode(3'd3);
        apb(1'b1, 8'h0c, 32'h20);
        op(4'h5);
        chk({31'h0, rd[5]}, 32'h1);
        op(4'h4);
        st_mode(3'd5);
        op(4'h5);
        st_mode(3'd0);
        op(4'h2);
        op(4'h4);
        chk({29'h0, rd[3:1]}, 32'h5);
        op(4'h6);
        chk({29'h0, rd[3:1]}, 32'h5);
        apb(1'b1, 8'h0c, 32'h20);
        apb(1'b1, 8'h08, 32'h1234);
        op(4'h8);
        chk({28'h0, rd[5], rd[3:1]}, 32'h5);
        op(4'h5);
        st_mode(3'd0);
        op(4'h2);
        op(4'h6);
        chk({29'h0, rd[3:1]}, 32'h0);
        $display("test sector erase done");
        for (k = 1; k < 3; k++) begin
            op(k[3:0]);
            op(4'h9);
            st_mode(3'd0);
            op(4'h7);
            chk({16'h0, rd[23:8]}, 32'h3000);
        end
        $display("test hardware reset done");
        test_done();
    end
endmodule // tb_top
